// >>> design/fdrc_top.sv
// Operation
// - Decimation code zero bypasses every decimation register in each cell.
// - Codes 01, 10, 11 insert one, two, three decimation registers per cell.
// - Coefficients advance every clock, or every second, third, fourth clock.
// - Decimation select is registered and acts one clock later.
// - A 26-bit three-state result bus shows a cell accumulator or output stage.
// - Shift-add select chooses cell accumulator or output stage adder result.
// - Low upper enable drives result bits 16 to 25, high floats them.
// - Low lower enable drives result bits 0 to 15, high floats them.
// - Cell select picks the cell read out or added into the output stage.
// - Cell select for readout and addition is registered, acting one clock later.
// - A held cell select keeps the first captured value, ignoring later updates.
// - Shift-add select activates output stage shift-and-add, one clock later.
// - Output stage adds selected accumulator to upper 18 buffer bits, or zero.
// - Low filter reset clears decimation and output stage registers, not accumulators, on the second clock.
// - Filter reset with accumulator clear also clears all cell accumulators.
// - Low accumulator clear clears only the addressed cell accumulator.
// - A single clear happens on the edge right after the clear request.
// - Reset plus clear together clear everything on the second clock.
`timescale 1ns/10ps
`default_nettype none

module fdrc_top
  (
    // Clock and reset.
    input  wire logic                               pclk,
    input  wire logic                               presetn,
    // APB slave.
    input  wire logic                               psel,
    input  wire logic                               penable,
    input  wire logic                               pwrite,
    input  wire logic [fdrc_pkg::APB_AW-1:0]        paddr,
    input  wire logic [31:0]                        pwdata,
    output logic      [31:0]                        prdata,
    output logic                                    pready,
    output logic                                    pslverr,
    // Control pins.
    input  wire fdrc_pkg::fdrc_ctl_t                ctl_pins,
    // Cell datapath.
    input  wire fdrc_pkg::fdrc_word_t [7:0]         cell_product,
    output logic      [2:0]                         decim_stages,
    output logic                                    coef_advance,
    // Result bus.
    output logic      [fdrc_pkg::RES_W-1:0]         result_bus_o,
    output logic                                    result_upper_oe,
    output logic                                    result_lower_oe
  );

  localparam int unsigned N = fdrc_pkg::NCELL;
  localparam int unsigned W = fdrc_pkg::RES_W;
  function automatic logic [7:0] onehot8(input logic [2:0] sel);
    onehot8 = 8'h01 << sel;
  endfunction
  fdrc_pkg::fdrc_ctl_t ctl_meta_ff;
  fdrc_pkg::fdrc_ctl_t ctl_s_ff;
  logic [1:0]          ctrl_ff;
  logic [1:0]          depth_ff;
  logic [1:0]          cnt_ff;
  logic [2:0]          cell_l_ff;
  logic [2:0]          cell_seen_ff;
  logic                first_ff;
  logic                shift_add_select_l_ff;
  logic                shift_add_select_p_ff;
  logic                freset_ff;
  logic                clear_all_ff;
  fdrc_pkg::fdrc_word_t [7:0] acc_ff;
  fdrc_pkg::fdrc_word_t hold_ff;
  fdrc_pkg::fdrc_word_t obuf_ff;
  logic [2:0]          decim_stages_ff;
  logic                coef_advance_ff;
  logic [W-1:0]        result_bus_ff;
  logic                upper_oe_ff;
  logic                lower_oe_ff;
  logic [31:0]         prdata_ff;
  logic                pready_ff;
  logic                pslverr_ff;

  logic                setup;
  logic                access;
  logic                new_addr;
  logic [7:0]          erase_hot;
  fdrc_pkg::fdrc_word_t sel_acc;
  fdrc_pkg::fdrc_word_t shift_term;
  fdrc_pkg::fdrc_word_t nxt_obuf;
  fdrc_pkg::fdrc_word_t nxt_result;
  logic [31:0]         nxt_prdata;
  logic                nxt_pslverr;

  // The pins come from outside this clock; the first stage is read only by the second.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctl_meta_ff <= fdrc_pkg::CTL_IDLE;
      ctl_s_ff    <= fdrc_pkg::CTL_IDLE;
    end
    else
    begin
      ctl_meta_ff <= ctl_pins;
      ctl_s_ff    <= ctl_meta_ff;
    end
  end

  // Internal latching of reset and the combined clear, one clock behind the synchronised pins.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      freset_ff    <= 1'b0;
      clear_all_ff <= 1'b0;
    end
    else
    begin
      freset_ff    <= ~ctl_s_ff.filter_reset_n | ctrl_ff[fdrc_pkg::CTRL_SOFT_RESET];
      clear_all_ff <= (~ctl_s_ff.filter_reset_n & ~ctl_s_ff.erase_n)
                      | ctrl_ff[fdrc_pkg::CTRL_SOFT_CLEAR];
    end
  end

  // Latched control inputs for readout and the output stage.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cell_l_ff  <= 3'h0;
      shift_add_select_l_ff <= 1'b0;
      shift_add_select_p_ff <= 1'b0;
    end
    else
    begin
      cell_l_ff  <= ctl_s_ff.cell_select;
      shift_add_select_l_ff <= ctl_s_ff.shift_add_select;
      shift_add_select_p_ff <= shift_add_select_l_ff;
    end
  end

  // Decimation depth and coefficient advance timing.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      depth_ff        <= fdrc_pkg::DECIM_NONE;
      cnt_ff          <= 2'h0;
      decim_stages_ff <= 3'h0;
      coef_advance_ff <= 1'b0;
    end
    else if (freset_ff)
    begin
      depth_ff        <= fdrc_pkg::DECIM_NONE;
      cnt_ff          <= 2'h0;
      decim_stages_ff <= 3'h0;
      coef_advance_ff <= 1'b0;
    end
    else
    begin
      depth_ff        <= ctl_s_ff.decimation_select;
      decim_stages_ff <= 3'((4'h1 << depth_ff) - 4'h1);
      if (cnt_ff >= depth_ff)
      begin
        cnt_ff          <= 2'h0;
        coef_advance_ff <= 1'b1;
      end
      else
      begin
        cnt_ff          <= 2'(cnt_ff + 2'h1);
        coef_advance_ff <= 1'b0;
      end
    end
  end

  assign erase_hot = ctl_s_ff.erase_n ? 8'h00 : onehot8(ctl_s_ff.cell_select);

  // Cell accumulators; the filter reset alone leaves them untouched.
  genvar gi;
  generate
    for (gi = 0; gi < N; gi++)
    begin : g_acc
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
          acc_ff[gi] <= '0;
        else if (clear_all_ff || erase_hot[gi])
          acc_ff[gi] <= '0;
        else
          acc_ff[gi] <= W'(acc_ff[gi] + cell_product[gi]);
      end
    end
  endgenerate

  assign sel_acc    = acc_ff[cell_l_ff];
  assign new_addr   = first_ff | (cell_l_ff != cell_seen_ff);
  // The buffer upper bits are shifted down arithmetically, so eight LSBs are dropped.
  assign shift_term = shift_add_select_l_ff ? W'({{8{obuf_ff[W-1]}}, obuf_ff[W-1:W-fdrc_pkg::SHIFT_W]}) : '0;
  assign nxt_obuf   = W'(sel_acc + shift_term);
  assign nxt_result = (!shift_add_select_l_ff && !shift_add_select_p_ff) ? hold_ff : obuf_ff;

  // Output stage and first-clock capture of the addressed accumulator.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cell_seen_ff  <= 3'h0;
      first_ff      <= 1'b1;
      hold_ff       <= '0;
      obuf_ff       <= '0;
      result_bus_ff <= '0;
    end
    else if (freset_ff)
    begin
      cell_seen_ff  <= 3'h0;
      first_ff      <= 1'b1;
      hold_ff       <= '0;
      obuf_ff       <= '0;
      result_bus_ff <= '0;
    end
    else
    begin
      cell_seen_ff  <= cell_l_ff;
      first_ff      <= 1'b0;
      if (new_addr)
        hold_ff <= sel_acc;
      obuf_ff       <= nxt_obuf;
      result_bus_ff <= nxt_result;
    end
  end

  // Half enables follow the synchronised pins; high on the pin floats that half.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      upper_oe_ff <= 1'b0;
      lower_oe_ff <= 1'b0;
    end
    else
    begin
      upper_oe_ff <= ~ctl_s_ff.result_upper_enable_n;
      lower_oe_ff <= ~ctl_s_ff.result_lower_enable_n;
    end
  end

  // APB slave, zero wait states: the answer is prepared in the setup cycle.
  assign setup  = psel & ~penable;
  assign access = psel & penable & pready_ff;

  always_comb
  begin
    nxt_prdata  = 32'h0000_0000;
    nxt_pslverr = 1'b0;
    unique case (paddr)
      fdrc_pkg::OFS_CTRL:   nxt_prdata = {30'h0, ctrl_ff};
      fdrc_pkg::OFS_STATUS: nxt_prdata = {25'h0, freset_ff, shift_add_select_l_ff, cell_l_ff, depth_ff};
      fdrc_pkg::OFS_RESULT: nxt_prdata = {6'h0, result_bus_ff};
      fdrc_pkg::OFS_OBUF:   nxt_prdata = {6'h0, obuf_ff};
      default:              nxt_pslverr = 1'b1;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata_ff  <= 32'h0000_0000;
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
    end
    else
    begin
      pready_ff  <= setup;
      pslverr_ff <= setup & nxt_pslverr;
      prdata_ff  <= (setup && !pwrite) ? nxt_prdata : 32'h0000_0000;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ctrl_ff <= fdrc_pkg::CTRL_RESET_VAL;
    else if (access && pwrite && paddr == fdrc_pkg::OFS_CTRL)
      ctrl_ff <= pwdata[1:0];
  end

  assign prdata          = prdata_ff;
  assign pready          = pready_ff;
  assign pslverr         = pslverr_ff;
  assign decim_stages    = decim_stages_ff;
  assign coef_advance    = coef_advance_ff;
  assign result_bus_o    = result_bus_ff;
  assign result_upper_oe = upper_oe_ff;
  assign result_lower_oe = lower_oe_ff;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  AST_DECIM_BYPASS: assert property (
    !freset_ff && !$past(freset_ff) && $past(ctl_s_ff.decimation_select, 2) == 2'h0
    |-> decim_stages_ff == 3'h0)
    else $error("decimation registers not bypassed for code zero");
  AST_DECIM_THREE: assert property (
    !$past(freset_ff) && !$past(freset_ff, 2) && $past(ctl_s_ff.decimation_select, 2) == 2'h3
    |-> decim_stages_ff == 3'h7)
    else $error("code three does not use three decimation registers");
  AST_ADV_EVERY_SECOND: assert property (
    (depth_ff == 2'h1 && !freset_ff && coef_advance_ff) ##1 (depth_ff == 2'h1 && !freset_ff)
    |-> !coef_advance_ff ##1 coef_advance_ff)
    else $error("coefficients do not advance every second clock");
  AST_DEPTH_LATCH: assert property (
    !freset_ff |=> depth_ff == $past(ctl_s_ff.decimation_select))
    else $error("decimation select not taken one clock later");
  AST_UPPER_EN: assert property (
    ctl_s_ff.result_upper_enable_n |=> !result_upper_oe)
    else $error("upper half driven while its enable is high");
  AST_LOWER_EN: assert property (
    !ctl_s_ff.result_lower_enable_n |=> result_lower_oe)
    else $error("lower half floating while its enable is low");
  AST_SINGLE_ERASE: assert property (
    !ctl_s_ff.erase_n && !clear_all_ff |=> acc_ff[$past(ctl_s_ff.cell_select)] == '0)
    else $error("addressed accumulator not cleared on next edge");
  AST_FULL_CLEAR: assert property (
    !ctl_s_ff.filter_reset_n && !ctl_s_ff.erase_n |=> ##1 acc_ff == '0)
    else $error("accumulators not all cleared on second clock");
  AST_RESET_KEEPS_ACC: assert property (
    freset_ff && !clear_all_ff && ctl_s_ff.erase_n && acc_ff[0] != '0 && cell_product[0] == '0
    |=> acc_ff[0] == $past(acc_ff[0]))
    else $error("filter reset alone disturbed an accumulator");
  AST_HOLD_FIXED: assert property (
    !freset_ff && !new_addr && $stable(cell_l_ff) |=> hold_ff == $past(hold_ff))
    else $error("held result changed while the address stayed put");
  // The expected sum is rebuilt from the accumulator and the previous buffer, not from the adder's nets.
  AST_SHIFT_ADD: assert property (
    !freset_ff && shift_add_select_l_ff |=> obuf_ff == W'($past(acc_ff[cell_l_ff])
      + {{8{$past(obuf_ff[W-1])}}, $past(obuf_ff[W-1:8])}))
    else $error("output stage sum wrong");
  CV_DECIM_TWO: cover property (depth_ff == 2'h2 && coef_advance_ff);
  CV_SHIFT_ADD: cover property (shift_add_select_l_ff ##1 shift_add_select_l_ff ##1 !shift_add_select_l_ff);
  CV_ERASE:     cover property (!ctl_s_ff.erase_n && ctl_s_ff.filter_reset_n);
  CV_APB_WRITE: cover property (access && pwrite);

endmodule

`default_nettype wire

// >>> design/fdrc_pkg.sv
package fdrc_pkg;

  localparam int unsigned NCELL     = 8;
  localparam int unsigned RES_W     = 26;
  localparam int unsigned SHIFT_W   = 18;
  localparam int unsigned LOW_HALF  = 16;
  localparam int unsigned APB_AW    = 12;

  // Register byte offsets.
  localparam logic [11:0] OFS_CTRL   = 12'h000;
  localparam logic [11:0] OFS_STATUS = 12'h004;
  localparam logic [11:0] OFS_RESULT = 12'h008;
  localparam logic [11:0] OFS_OBUF   = 12'h00c;

  // CTRL field positions and reset value.
  localparam int unsigned CTRL_SOFT_RESET = 0;
  localparam int unsigned CTRL_SOFT_CLEAR = 1;
  localparam logic [1:0]  CTRL_RESET_VAL  = 2'h0;

  // STATUS field positions.
  localparam int unsigned ST_DECIM_LSB = 0;
  localparam int unsigned ST_CELL_LSB  = 2;
  localparam int unsigned ST_SHIFT_ADD_SELECT     = 5;
  localparam int unsigned ST_FRESET    = 6;

  localparam logic [1:0] DECIM_NONE = 2'h0;

  typedef logic [RES_W-1:0] fdrc_word_t;

  // Control pins, carried together through the synchroniser.
  typedef struct packed {
    logic [1:0] decimation_select;
    logic [2:0] cell_select;
    logic       shift_add_select;
    logic       filter_reset_n;
    logic       erase_n;
    logic       result_upper_enable_n;
    logic       result_lower_enable_n;
  } fdrc_ctl_t;

  localparam fdrc_ctl_t CTL_IDLE = '{2'h0, 3'h0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1};

endpackage

// >>> bench/fdrc_host.sv
`timescale 1ns/10ps
`default_nettype none

module fdrc_host
  (
    // Clock.
    input  wire logic        pclk,
    // Result pins of the block.
    input  wire logic [25:0] result_bus_o,
    input  wire logic        result_upper_oe,
    input  wire logic        result_lower_oe,
    // Level that the host sees on its shared bus.
    output logic      [25:0] bus_seen
  );
  // A floating half shows a toggling pattern, so stale data never passes for a driven value.
  logic [25:0] last_ff;

  always_ff @(posedge pclk)
  begin
    last_ff <= bus_seen;
  end

  always_comb
  begin
    bus_seen[25:16] = result_upper_oe ? result_bus_o[25:16] : ~last_ff[25:16];
    bus_seen[15:0]  = result_lower_oe ? result_bus_o[15:0] : ~last_ff[15:0];
  end
endmodule

`default_nettype wire

// >>> bench/tb_fir_decimation_result_control.sv
`timescale 1ns/10ps
`default_nettype none

`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin fails++; \
  $display("wrong value at %0t: got %h expected %h", $time, g, e); end end

module tb_fir_decimation_result_control;
  typedef struct packed {logic [2:0] src; logic [32:0] val;} fdrc_note_t;
  localparam logic [4:0] RD = 5'h0c, SH = 5'h1c, CLR = 5'h00, RST = 5'h04, ER = 5'h08;

  logic                          pclk, presetn, psel, penable, pwrite, pready, pslverr, coef_advance, look;
  logic                          result_upper_oe, result_lower_oe;
  logic [11:0]                   paddr;
  logic [31:0]                   pwdata, prdata;
  fdrc_pkg::fdrc_ctl_t           ctl;
  fdrc_pkg::fdrc_word_t [7:0]    prod;
  logic [2:0]                    decim_stages;
  logic [25:0]                   result_bus_o, bus_seen;
  logic [25:0]                   acc [8];
  logic [32:0]                   gap, g;
  fdrc_note_t                    q [$];
  fdrc_note_t                    nt;
  int                            fails, n_checks, cyc, i;
  integer                        seed;

  fdrc_top u_fdrc_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .ctl_pins(ctl),
    .cell_product(prod), .decim_stages(decim_stages), .coef_advance(coef_advance),
    .result_bus_o(result_bus_o), .result_upper_oe(result_upper_oe), .result_lower_oe(result_lower_oe));
  fdrc_host u_fdrc_host (.pclk(pclk), .result_bus_o(result_bus_o), .result_upper_oe(result_upper_oe),
    .result_lower_oe(result_lower_oe), .bus_seen(bus_seen));

  always #5 pclk = ~pclk;

  task test_done;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (!pready);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task rd(input logic [11:0] a, input logic [32:0] v);
    q.push_back('{3'd0, v});
    apb(1'b0, a, 32'h0);
  endtask

  task ex(input logic [2:0] s, input logic [32:0] v);
    q.push_back('{s, v});
    @(posedge pclk);
    look <= 1'b1;
    @(posedge pclk);
    look <= 1'b0;
  endtask

  // The pins pass a two-flop synchroniser, so each setting is held well past its latency.
  task setc(input logic [2:0] c, input logic [4:0] f);
    @(posedge pclk);
    ctl <= {2'h0, c, f};
    repeat (8) @(posedge pclk);
  endtask

  function automatic logic [32:0] fp(input logic [25:0] a);
    logic signed [25:0] x;
    x = '0;
    repeat (40) x = $signed(a) + (x >>> 8);
    return {7'h0, x};
  endfunction

  always @(posedge pclk)
  begin
    if ((look || (psel && penable && pready && !pwrite)) && q.size() != 0)
    begin
      nt = q.pop_front();
      case (nt.src)
        3'd0: g = {pslverr, prdata};
        3'd2: g = {7'h0, bus_seen};
        3'd3: g = {30'h0, decim_stages};
        3'd4: g = {31'h0, result_upper_oe, result_lower_oe};
        default: g = gap;
      endcase
      `CHK(g, nt.val)
    end
  end

  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      fails++;
      test_done;
    end
  end

  initial
  begin
    pclk = 1'b0; presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; look = 1'b0;
    paddr = '0; pwdata = '0; ctl = fdrc_pkg::CTL_IDLE; prod = '0; seed = 32'h42d91caa;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b1, fdrc_pkg::OFS_CTRL, 32'h1);
    repeat (3) @(posedge pclk);
    rd(fdrc_pkg::OFS_CTRL, 33'h1);
    rd(fdrc_pkg::OFS_STATUS, 33'h40);
    apb(1'b1, fdrc_pkg::OFS_CTRL, 32'h0);
    apb(1'b1, fdrc_pkg::OFS_STATUS, 32'hffff);
    rd(fdrc_pkg::OFS_STATUS, 33'h0);
    rd(12'h010, 33'h100000000);
    $display("test register access done");
    for (i = 0; i < 4; i++)
    begin
      @(posedge pclk);
      ctl.decimation_select <= 2'(i);
      repeat (8) @(posedge pclk);
      while (!coef_advance) @(posedge pclk);
      gap = '0;
      do begin @(posedge pclk); gap++; end while (!coef_advance);
      ex(3'd5, 33'(i + 1));
      ex(3'd3, {i == 3, i >= 2, i >= 1});
    end
    $display("test decimation done");
    setc(3'h0, CLR);
    setc(3'h0, RD);
    @(posedge pclk);
    for (i = 0; i < 8; i++)
    begin
      acc[i] = 26'($random(seed)) & 26'h00ffff;
      prod[i] <= acc[i];
      acc[i] = acc[i] * 5;
    end
    repeat (5) @(posedge pclk);
    prod <= '0;
    for (i = 1; i < 9; i++)
    begin
      setc(3'(i), RD);
      ex(3'd2, acc[i & 7]);
    end
    prod[0] <= 26'h1;
    repeat (3) @(posedge pclk);
    prod <= '0;
    repeat (4) @(posedge pclk);
    ex(3'd2, acc[0]);
    setc(3'h3, ER);
    setc(3'h2, RD);
    ex(3'd2, acc[2]);
    setc(3'h3, RD);
    ex(3'd2, 33'h0);
    setc(3'h6, RST);
    setc(3'h5, RD);
    ex(3'd2, acc[5]);
    $display("test readout and clear done");
    setc(3'h5, 5'h0f);
    ex(3'd4, 33'h0);
    setc(3'h5, 5'h0d);
    ex(3'd4, 33'h2);
    // Cell 1 is addressed here so the buffer already holds its accumulator when shift-and-add starts.
    setc(3'h1, 5'h0e);
    ex(3'd4, 33'h1);
    $display("test enables done");
    setc(3'h1, SH);
    repeat (40) @(posedge pclk);
    ex(3'd2, fp(acc[1]));
    rd(fdrc_pkg::OFS_OBUF, fp(acc[1]));
    setc(3'h1, RD);
    rd(fdrc_pkg::OFS_OBUF, acc[1]);
    rd(fdrc_pkg::OFS_RESULT, acc[1]);
    $display("test shift and add done");
    setc(3'h4, CLR);
    setc(3'h7, RD);
    ex(3'd2, 33'h0);
    $display("test full clear done");
    test_done;
  end
endmodule

`default_nettype wire
